/* File: src/mdmls_ahb_slave.sv */
`timescale 1ns/1ps
`include "mdmls_params.svh"
module mdmls_ahb_slave
    import mdmls_pkg::*;
(
    input  wire logic        hclk,       // Bus clock
    input  wire logic        hresetn,    // Async reset, active low
    input  wire logic        hsel,       // Slave select
    input  wire logic [31:0] haddr,      // Byte address
    input  wire logic [1:0]  htrans,     // Transfer type
    input  wire logic        hwrite,     // Write not read
    input  wire logic [2:0]  hsize,      // Transfer size
    input  wire logic [31:0] hwdata,     // Write data
    input  wire logic        hready,     // Bus ready
    output logic      [31:0] hrdata_q,   // Read data
    output logic             hreadyout_q,// Ready out
    mdmls_regbus_if.slave    rb          // Register side
);

    mdmls_bus_state_type state_q;
    logic [9:0]          idx_q;
    logic                ok_q;
    logic                accept;

    // Address phase is taken on a NONSEQ or SEQ transfer while ready
    assign accept      = hsel & htrans[1] & hready;
    assign rb.wr_en    = (state_q == MDMLS_BUS_WRITE);
    assign rb.addr_idx = idx_q;
    assign rb.addr_ok  = ok_q;
    assign rb.wdata    = hwdata;

    // Phase tracking; reads insert one wait state so that a write just before is seen
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_q     <= MDMLS_BUS_IDLE;
            idx_q       <= 10'h000;
            ok_q        <= 1'b0;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
        end
        else
        begin
            case (state_q)
                MDMLS_BUS_IDLE, MDMLS_BUS_WRITE:
                begin
                    if (accept)
                    begin
                        idx_q <= haddr[11:2];
                        ok_q  <= (haddr[31:12] == 20'h00000) && (haddr[1:0] == 2'b00)
                                 && (hsize == `MDMLS_HSIZE_WORD);
                        if (hwrite)
                            state_q <= MDMLS_BUS_WRITE;
                        else
                        begin
                            state_q     <= MDMLS_BUS_READ;
                            hreadyout_q <= 1'b0;
                        end
                    end
                    else
                        state_q <= MDMLS_BUS_IDLE;
                end
                MDMLS_BUS_READ:
                begin
                    hrdata_q    <= rb.rdata;
                    hreadyout_q <= 1'b1;
                    state_q     <= MDMLS_BUS_IDLE;
                end
                default:
                begin
                    state_q     <= MDMLS_BUS_IDLE;
                    hreadyout_q <= 1'b1;
                end
            endcase
        end
    end

endmodule

/* File: src/mdmls_baud_monitor.sv */
`timescale 1ns/1ps
`include "mdmls_params.svh"
module mdmls_baud_monitor
    import mdmls_pkg::*;
(
    input  wire logic        hclk,          // Clock
    input  wire logic        hresetn,       // Async reset, active low
    input  wire logic        baud_tick,     // One pulse per baud boundary
    input  wire logic [15:0] line_energy,   // Received line energy
    input  wire logic [15:0] eye_quality_level, // Eye quality level
    input  wire logic        eye_mode,      // Eye monitor mode active
    input  wire logic [15:0] found_wr,      // Host signal-found threshold
    input  wire logic [15:0] lost_wr,       // Host signal-lost threshold
    input  wire logic [15:0] limit_wr,      // Host eye limit
    output logic             carrier_q,     // Carrier detect flag
    output logic             eye_exceed_q   // Eye over limit, one-cycle pulse
);

    logic [15:0] found_act_q;
    logic [15:0] lost_act_q;
    logic [15:0] limit_act_q;

    // Host values become active at the next baud boundary
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            found_act_q <= `MDMLS_RST_FOUND_THR;  // [R9]
            lost_act_q  <= `MDMLS_RST_LOST_THR;   // [R9]
            limit_act_q <= `MDMLS_RST_EYE_LIMIT;  // [R6]
        end
        else if (baud_tick)
        begin
            found_act_q <= found_wr;  // [R9]
            lost_act_q  <= lost_wr;   // [R9]
            limit_act_q <= limit_wr;  // [R6]
        end
    end

    // Carrier detect with hysteresis, evaluated at baud boundaries
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            carrier_q <= 1'b0;
        else if (baud_tick)  // [R13]
        begin
            if (carrier_q && (line_energy < lost_act_q))
                carrier_q <= 1'b0;  // [R7]
            else if (!carrier_q && (line_energy > found_act_q))
                carrier_q <= 1'b1;  // [R8]
        end
    end

    // Eye quality comparison at baud boundaries
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            eye_exceed_q <= 1'b0;
        else
            eye_exceed_q <= baud_tick && eye_mode
                            && (eye_quality_level > limit_act_q);  // [R5] [R13]
    end

endmodule

/* File: src/mdmls_params.svh */
`ifndef MDMLS_PARAMS_SVH
`define MDMLS_PARAMS_SVH

// Register word indices; byte address is four times the index
`define MDMLS_IDX_LINK_MODE    10'h1f0
`define MDMLS_IDX_FOUND_THR    10'h1f4
`define MDMLS_IDX_LOST_THR     10'h1f5
`define MDMLS_IDX_EYE_LIMIT    10'h1f6
`define MDMLS_IDX_OPMODE       10'h1e0
`define MDMLS_IDX_HOOK_CTRL    10'h1e1
`define MDMLS_IDX_PUMP_CTRL    10'h1e2
`define MDMLS_IDX_STATUS5      10'h1e3

// Field positions
`define MDMLS_HOOK_BIT         2
`define MDMLS_EYE_ERR_BIT      4
`define MDMLS_CARRIER_BIT      1
`define MDMLS_MODE_MSB         6

// Reset values
`define MDMLS_RST_EYE_LIMIT    16'h0400
`define MDMLS_RST_FOUND_THR    16'h00e8
`define MDMLS_RST_LOST_THR     16'h0082
`define MDMLS_RST_LINK_MODE    16'h0000
`define MDMLS_RST_OPMODE       7'h00

// Bus decode
`define MDMLS_HSIZE_WORD       3'b010

`endif

/* File: src/mdmls_pkg.sv */
package mdmls_pkg;

    // Operating and negotiated mode codes
    typedef enum logic [6:0]
    {
        MDMLS_MODE_IDLE       = 7'h00,
        MDMLS_MODE_DIAL       = 7'h03,
        MDMLS_MODE_TONES      = 7'h04,
        MDMLS_MODE_V22BIS     = 7'h08,
        MDMLS_MODE_V22        = 7'h09,
        MDMLS_MODE_LEG1200    = 7'h0b,
        MDMLS_MODE_V21        = 7'h10,
        MDMLS_MODE_LEG300     = 7'h11,
        MDMLS_MODE_V23_FWD    = 7'h13,
        MDMLS_MODE_V23_REV    = 7'h14
    } mdmls_mode_type;

    // Bus slave phase
    typedef enum logic [1:0]
    {
        MDMLS_BUS_IDLE  = 2'b00,
        MDMLS_BUS_WRITE = 2'b01,
        MDMLS_BUS_READ  = 2'b10
    } mdmls_bus_state_type;

    // True for any data mode code
    function automatic logic mdmls_is_data_mode(input logic [6:0] m);
        logic r;
        r = 1'b0;
        case (m)
            7'h08, 7'h09, 7'h0b, 7'h10, 7'h11, 7'h13, 7'h14: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // True for the modes in which the eye monitor is active
    function automatic logic mdmls_is_eye_mode(input logic [6:0] m);
        logic r;
        r = 1'b0;
        case (m)
            7'h08, 7'h09, 7'h0b: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

endpackage

/* File: src/mdmls_regbus_if.sv */
`timescale 1ns/1ps
interface mdmls_regbus_if;
    logic        wr_en;      // Write strobe, data phase
    logic        addr_ok;    // Address below 4 KB, word aligned and word sized
    logic [9:0]  addr_idx;   // Word index
    logic [31:0] wdata;      // Write data
    logic [31:0] rdata;      // Read data from register file

    modport slave (output wr_en, output addr_ok, output addr_idx, output wdata, input rdata);
    modport regs  (input wr_en, input addr_ok, input addr_idx, input wdata, output rdata);
endinterface

/* File: src/mdmls_top.sv */
// How it works
// R1: Hook relay pin is driven low exactly when hook relay enable is one; the code drives the pin from a flop one clock behind the enable.
// R2: Writing operating mode dial or any data mode sets hook relay enable.
// R3: Hook relay enable is cleared by reset.
// R4: Host writes hook relay enable only while operating mode is idle; the code accepts hook writes in any operating mode.
// R5: In the three QAM/DPSK data modes, eye level above limit sets error flag.
// R6: Eye limit resets to 400h; a new limit applies at the next baud boundary.
// R7: Carrier detect clears when line energy drops below the signal-lost threshold.
// R8: Carrier detect sets when line energy rises above the signal-found threshold.
// R9: Thresholds reset to -48 and -43 dBm; host values apply after next baud.
// R10: Negotiated link mode is written with the mode when handshake completes.
// R11: Link mode codes 8, 9 and B for the 2400 and 1200 bps modes.
// R12: Link mode codes 10, 11, 13 and 14 for the slow FSK modes.
// R13: Thresholds are compared once per baud period; flags change only then.
`timescale 1ns/1ps
`include "mdmls_params.svh"
module mdmls_top
    import mdmls_pkg::*;
(
    input  wire logic        hclk,              // Bus and pump clock, 40 MHz
    input  wire logic        hresetn,           // Async reset, active low
    input  wire logic        hsel,              // AHB select
    input  wire logic [31:0] haddr,             // AHB address
    input  wire logic [1:0]  htrans,            // AHB transfer type
    input  wire logic        hwrite,            // AHB write
    input  wire logic [2:0]  hsize,             // AHB size
    input  wire logic [31:0] hwdata,            // AHB write data
    input  wire logic        hready,            // AHB ready in
    output logic      [31:0] hrdata,            // AHB read data
    output logic             hreadyout,         // AHB ready out
    output logic             hresp,             // AHB response, always OKAY
    input  wire logic        baud_tick,         // Baud boundary pulse from pump
    input  wire logic [15:0] line_energy,       // Received line energy
    input  wire logic [15:0] eye_quality_level, // Eye quality level
    input  wire logic        handshake_done,    // Handshake complete pulse
    input  wire logic [6:0]  handshake_mode,    // Mode reached by handshake
    output logic             hook_relay_pin_n   // Hook relay drive, low = off hook
);

    mdmls_regbus_if rb ();

    logic [6:0]  opmode_q;
    logic        hook_relay_enable_q;
    logic        hook_pin_n_q;
    logic        eye_quality_error_flag_q;
    logic [15:0] negotiated_link_mode_q;
    logic [15:0] signal_found_threshold_q;
    logic [15:0] signal_lost_threshold_q;
    logic [15:0] eye_quality_max_limit_q;
    logic        carrier_detect_flag;
    logic        eye_exceed;
    logic        hresp_q;
    logic [31:0] bus_rdata;
    logic [31:0] bus_rdata_q;
    logic        bus_ready_q;

    // Bus front end
    mdmls_ahb_slave u_slave
    (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hsize       (hsize),
        .hwdata      (hwdata),
        .hready      (hready),
        .hrdata_q    (bus_rdata_q),
        .hreadyout_q (bus_ready_q),
        .rb          (rb)
    );

    // Per-baud threshold comparisons
    mdmls_baud_monitor u_monitor
    (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .baud_tick         (baud_tick),
        .line_energy       (line_energy),
        .eye_quality_level (eye_quality_level),
        .eye_mode          (mdmls_is_eye_mode(opmode_q)),
        .found_wr          (signal_found_threshold_q),
        .lost_wr           (signal_lost_threshold_q),
        .limit_wr          (eye_quality_max_limit_q),
        .carrier_q         (carrier_detect_flag),
        .eye_exceed_q      (eye_exceed)
    );

    // Write strobe for one register index
    function automatic logic wr_hit(input logic [9:0] idx);
        return rb.wr_en && rb.addr_ok && (rb.addr_idx == idx);
    endfunction

    // Operating mode field
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            opmode_q <= `MDMLS_RST_OPMODE;
        else if (wr_hit(`MDMLS_IDX_OPMODE))
            opmode_q <= rb.wdata[`MDMLS_MODE_MSB:0];
    end

    // Hook relay enable and its inverted pin, both from flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hook_relay_enable_q <= 1'b0;  // [R3]
            hook_pin_n_q        <= 1'b1;  // [R3]
        end
        else
        begin
            if (wr_hit(`MDMLS_IDX_OPMODE) &&
                ((rb.wdata[`MDMLS_MODE_MSB:0] == MDMLS_MODE_DIAL) ||
                 mdmls_is_data_mode(rb.wdata[`MDMLS_MODE_MSB:0])))
                hook_relay_enable_q <= 1'b1;  // [R2]
            else if (wr_hit(`MDMLS_IDX_HOOK_CTRL))
                hook_relay_enable_q <= rb.wdata[`MDMLS_HOOK_BIT];  // [R4]
            hook_pin_n_q <= ~hook_relay_enable_q;  // [R1]
        end
    end

    // Eye error flag: sticky, host clears by writing zero, a new event wins
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            eye_quality_error_flag_q <= 1'b0;
        else if (eye_exceed)
            eye_quality_error_flag_q <= 1'b1;  // [R5]
        else if (wr_hit(`MDMLS_IDX_PUMP_CTRL) && !rb.wdata[`MDMLS_EYE_ERR_BIT])
            eye_quality_error_flag_q <= 1'b0;
    end

    // Host-written threshold and limit values
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            signal_found_threshold_q <= `MDMLS_RST_FOUND_THR;  // [R9]
            signal_lost_threshold_q  <= `MDMLS_RST_LOST_THR;   // [R9]
            eye_quality_max_limit_q  <= `MDMLS_RST_EYE_LIMIT;  // [R6]
        end
        else
        begin
            if (wr_hit(`MDMLS_IDX_FOUND_THR))
                signal_found_threshold_q <= rb.wdata[15:0];
            if (wr_hit(`MDMLS_IDX_LOST_THR))
                signal_lost_threshold_q <= rb.wdata[15:0];
            if (wr_hit(`MDMLS_IDX_EYE_LIMIT))
                eye_quality_max_limit_q <= rb.wdata[15:0];
        end
    end

    // Negotiated link mode, loaded by the pump when handshake completes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            negotiated_link_mode_q <= `MDMLS_RST_LINK_MODE;
        else if (handshake_done)
            negotiated_link_mode_q <= {9'h000, handshake_mode};  // [R10] [R11] [R12]
    end

    // Read data mux; unmapped or non-word accesses read zero
    always_comb
    begin
        bus_rdata = 32'h0000_0000;
        if (rb.addr_ok)
        begin
            case (rb.addr_idx)
                `MDMLS_IDX_LINK_MODE: bus_rdata = {16'h0000, negotiated_link_mode_q};
                `MDMLS_IDX_FOUND_THR: bus_rdata = {16'h0000, signal_found_threshold_q};
                `MDMLS_IDX_LOST_THR:  bus_rdata = {16'h0000, signal_lost_threshold_q};
                `MDMLS_IDX_EYE_LIMIT: bus_rdata = {16'h0000, eye_quality_max_limit_q};
                `MDMLS_IDX_OPMODE:    bus_rdata = {25'h0000000, opmode_q};
                `MDMLS_IDX_HOOK_CTRL: bus_rdata = {29'h00000000, hook_relay_enable_q, 2'b00};
                `MDMLS_IDX_PUMP_CTRL: bus_rdata = {27'h0000000, eye_quality_error_flag_q, 4'h0};
                `MDMLS_IDX_STATUS5:   bus_rdata = {30'h00000000, carrier_detect_flag, 1'b0};
                default:              bus_rdata = 32'h0000_0000;
            endcase
        end
    end
    assign rb.rdata = bus_rdata;

    // Response is always OKAY
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hresp_q <= 1'b0;
        else
            hresp_q <= 1'b0;
    end

    assign hrdata           = bus_rdata_q;
    assign hreadyout        = bus_ready_q;
    assign hresp            = hresp_q;
    assign hook_relay_pin_n = hook_pin_n_q;

endmodule

/* File: tb/mdmls_pump_model.sv */
`timescale 1ns/1ps
module mdmls_pump_model
    import mdmls_pkg::*;
#(
    parameter int BAUD = 16
)
(
    input  wire logic        hclk,              // Clock
    input  wire logic        hresetn,           // Reset, active low
    input  wire logic        run,               // Baud timing running
    input  wire logic [15:0] e_in,              // Energy to present
    input  wire logic [15:0] q_in,              // Eye level to present
    output logic             baud_tick,         // Baud boundary pulse
    output logic [15:0]      line_energy,       // Received line energy
    output logic [15:0]      eye_quality_level  // Eye quality level
);
    logic [7:0] cnt_q;

    // Baud period counter; no boundary pulses while stopped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_q     <= 8'h00;
            baud_tick <= 1'b0;
        end
        else
        begin
            cnt_q     <= (cnt_q == 8'(BAUD - 1)) ? 8'h00 : cnt_q + 8'h01;
            baud_tick <= run && (cnt_q == 8'(BAUD - 1));
        end
    end

    // Measured levels follow the requested ones
    always_ff @(posedge hclk)
    begin
        line_energy       <= e_in;
        eye_quality_level <= q_in;
    end
endmodule

/* File: tb/mdmls_top_sva.sv */
`timescale 1ns/1ps
module mdmls_top_sva
    import mdmls_pkg::*;
(
    input wire logic        hclk,              // Clock
    input wire logic        hresetn,           // Reset, active low
    input wire logic        hsel,              // Select
    input wire logic [31:0] haddr,             // Address
    input wire logic [1:0]  htrans,            // Transfer type
    input wire logic        hwrite,            // Write
    input wire logic [31:0] hwdata,            // Write data
    input wire logic        hready,            // Ready in
    input wire logic [31:0] hrdata,            // Read data
    input wire logic        hreadyout,         // Ready out
    input wire logic        hresp,             // Response
    input wire logic        hook_relay_pin_n   // Relay drive
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic        wp_q;
    logic [31:0] ad_q;
    wire         take = hsel && htrans[1] && hready;

    // Write data phase marker and its address
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp_q <= 1'b0;
            ad_q <= 32'h0;
        end
        else
        begin
            wp_q <= take && hwrite;
            ad_q <= haddr;
        end
    end

    // One wait state, then data
    sequence s_rd_ans;
        ##1 !hreadyout ##1 hreadyout;
    endsequence

    AST_HOOK_WR: assert property (wp_q && ad_q == 32'h784 |->
        ##2 hook_relay_pin_n == !$past(hwdata[2], 2))
        else $error("relay pin does not follow hook write");
    AST_HOOK_MODE: assert property (wp_q && ad_q == 32'h780 && hwdata[6:0] inside
        {7'h03, 7'h08, 7'h09, 7'h0b, 7'h10, 7'h11, 7'h13, 7'h14} |-> ##2 !hook_relay_pin_n)
        else $error("mode write did not take relay off hook");
    AST_RST_PIN: assert property ($rose(hresetn) |-> hook_relay_pin_n)
        else $error("relay not on hook after reset");
    AST_PIN_CAUSE: assert property ($changed(hook_relay_pin_n) |-> $past(wp_q, 2))
        else $error("relay pin moved without a host write");
    AST_RD_ANS: assert property (take && !hwrite |-> s_rd_ans)
        else $error("read answer timing wrong");
    AST_WR_ZERO: assert property (take && hwrite |-> ##1 hreadyout)
        else $error("write inserted wait state");
    AST_UNMAP: assert property (take && !hwrite && haddr[31:12] != 20'h0 |-> s_rd_ans ##0
        hrdata == 32'h0)
        else $error("unmapped read not zero");
    AST_OKAY: assert property (hresp == 1'b0)
        else $error("response not okay");
    AST_RST_BUS: assert property ($rose(hresetn) |-> hreadyout && hrdata == 32'h0)
        else $error("bus outputs not at reset values");
endmodule

bind mdmls_top mdmls_top_sva i_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .hook_relay_pin_n(hook_relay_pin_n));

/* File: tb/modem_line_status_registers_tb_top.sv */
`timescale 1ns/1ps
module modem_line_status_registers_tb_top;
    localparam int BAUD = 16;
    localparam logic [31:0] A_LINK = 32'h7c0, A_FOUND = 32'h7d0, A_LOST = 32'h7d4;
    localparam logic [31:0] A_LIMIT = 32'h7d8, A_OPM = 32'h780, A_HOOK = 32'h784;
    localparam logic [31:0] A_PUMP = 32'h788, A_ST5 = 32'h78c;
    localparam logic [6:0]  MODES [9] = '{7'h03, 7'h04, 7'h08, 7'h09, 7'h0b, 7'h10, 7'h11,
                                          7'h13, 7'h14};
    logic        hclk, hresetn, hwrite, run, handshake_done, baud_tick;
    logic        hreadyout, hresp, hook_relay_pin_n, rph;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] e_in, q_in, line_energy, eye_quality_level;
    logic [6:0]  handshake_mode;
    logic [31:0] exp_q [$];
    int          n_mismatch, check_count;

    mdmls_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .baud_tick(baud_tick),
        .line_energy(line_energy), .eye_quality_level(eye_quality_level),
        .handshake_done(handshake_done), .handshake_mode(handshake_mode),
        .hook_relay_pin_n(hook_relay_pin_n));

    mdmls_pump_model #(.BAUD(BAUD)) i_pump (.hclk(hclk), .hresetn(hresetn), .run(run),
        .e_in(e_in), .q_in(q_in), .baud_tick(baud_tick), .line_energy(line_energy),
        .eye_quality_level(eye_quality_level));

    // Clock, 25 ns period
    initial
    begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("BAD %0t read %h expected %h", $time, g, e);
        end
    endtask

    // Pin settles two edges after the write data phase
    task automatic chk_pin(input logic e);
        repeat (2) @(posedge hclk);
        check_count++;
        if (hook_relay_pin_n !== e)
        begin
            n_mismatch++;
            $display("BAD %0t relay pin %b expected %b", $time, hook_relay_pin_n, e);
        end
    endtask

    // Single transfer; each phase held until ready is seen high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hwrite <= w;
        haddr  <= a;
        htrans <= 2'b10;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask

    task automatic rst();
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    task automatic bauds(input int n);
        repeat (n * BAUD + 4) @(posedge hclk);
    endtask

    // Read results matched against the oldest expectation
    always @(posedge hclk)
    begin
        if (rph && hreadyout)
        begin
            chk_word(hrdata, exp_q.pop_front());
            rph = 1'b0;
        end
        if (hresetn && htrans[1] && hreadyout && !hwrite)
            rph = 1'b1;
        if (!hresetn)
            rph = 1'b0;
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_mismatch++;
        print_verdict();
    end

    // Main sequence
    initial
    begin
        {hwrite, run, handshake_done} = 3'h0;
        {haddr, hwdata, htrans, e_in, q_in, handshake_mode} = '0;
        hsize = 3'b010;
        hresetn = 1'b0;
        r = $urandom(32'hbc14afdc);
        rst();
        rd(A_LINK, 32'h0);
        rd(A_FOUND, 32'he8);
        rd(A_LOST, 32'h82);
        rd(A_LIMIT, 32'h400);
        chk_pin(1'b1);
        $display("test reset values done");
        wr(A_HOOK, 32'h4);
        chk_pin(1'b0);
        wr(A_HOOK, 32'h0);
        chk_pin(1'b1);
        foreach (MODES[i])
        begin
            wr(A_OPM, 32'h0);
            wr(A_HOOK, 32'h0);
            wr(A_OPM, {25'h0, MODES[i]});
            rd(A_HOOK, (MODES[i] == 7'h04) ? 32'h0 : 32'h4);
            chk_pin(MODES[i] == 7'h04);
        end
        $display("test hook relay done");
        foreach (MODES[i])
        begin
            r = $urandom;
            wr(A_FOUND + 32'(i % 3) * 4, r);
            rd(A_FOUND + 32'(i % 3) * 4, {16'h0, r[15:0]});
        end
        wr(A_LINK, r);
        rd(A_LINK, 32'h0);
        rd(32'h0001_07c0, 32'h0);
        wr(A_OPM, 32'h0);
        wr(A_HOOK, 32'h4);
        rst();
        chk_pin(1'b1);
        rd(A_HOOK, 32'h0);
        rd(A_LIMIT, 32'h400);
        rd(A_LOST, 32'h82);
        $display("test registers and reset done");
        wr(A_FOUND, 32'h100);
        wr(A_LOST, 32'h80);
        e_in <= 16'h101;
        bauds(2);
        rd(A_ST5, 32'h0);
        run <= 1'b1;
        bauds(2);
        rd(A_ST5, 32'h2);
        e_in <= 16'h90;
        bauds(2);
        rd(A_ST5, 32'h2);
        e_in <= 16'h7f;
        bauds(2);
        rd(A_ST5, 32'h0);
        e_in <= 16'h100;
        bauds(2);
        rd(A_ST5, 32'h0);
        $display("test carrier detect done");
        foreach (MODES[i])
        begin
            wr(A_OPM, {25'h0, MODES[i]});
            q_in <= 16'h401;
            bauds(2);
            rd(A_PUMP, (MODES[i] inside {7'h08, 7'h09, 7'h0b}) ? 32'h10 : 32'h0);
            q_in <= 16'h400;
            bauds(1);
            wr(A_PUMP, 32'h0);
            rd(A_PUMP, 32'h0);
        end
        wr(A_OPM, 32'h8);
        wr(A_LIMIT, 32'h500);
        bauds(1);
        q_in <= 16'h450;
        bauds(2);
        rd(A_PUMP, 32'h0);
        $display("test eye quality done");
        foreach (MODES[i])
        begin
            handshake_mode <= MODES[i];
            handshake_done <= 1'b1;
            @(posedge hclk);
            handshake_done <= 1'b0;
            rd(A_LINK, {25'h0, MODES[i]});
        end
        $display("test link mode done");
        print_verdict();
    end
endmodule
